// >>> bench/power_control_wakeup_properties.sv
// concurrent checks on the ports of the power control and wake-up block
`timescale 1ns/1ps
module power_control_wakeup_properties (
  input wire logic                clk,
  input wire logic                nrst,
  input wire logic                ce,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire power_pkg::irq_vec_t irq_request,
  input wire power_pkg::irq_vec_t irq_enable,
  input wire logic                idle_mode,
  input wire logic                power_down_mode,
  input wire logic                osc_run,
  input wire logic                cpu_hold
);
  int unsigned hold_cnt;
  // counts settling cycles after leaving power down
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hold_cnt <= 0;
    end else if (cpu_hold && !idle_mode && !power_down_mode) begin
      hold_cnt <= hold_cnt + 1;
    end else begin
      hold_cnt <= 0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_settle_hold_len: assert property ($fell(cpu_hold) && hold_cnt > 8 |-> hold_cnt == 256 || hold_cnt == 1024)
    else $error("settling hold length wrong");
  a_pd_osc_off: assert property (power_down_mode |-> !osc_run && cpu_hold)
    else $error("oscillator running in power down");
  a_pd_exit_osc: assert property ($fell(power_down_mode) |-> osc_run && cpu_hold)
    else $error("wake exit without oscillator restart");
  a_modes_exclusive: assert property (!(idle_mode && power_down_mode))
    else $error("idle and power down together");
  a_idle_exit: assert property (idle_mode && ce && |(irq_request & irq_enable) |-> ##[1:2] !idle_mode)
    else $error("idle not ended by enabled interrupt");
  a_idle_holds_cpu: assert property (idle_mode |-> cpu_hold && osc_run)
    else $error("idle without cpu hold");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce
    |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
endmodule // power_control_wakeup_properties

bind power_control_wakeup power_control_wakeup_properties chk (.clk, .nrst, .ce, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq_request, .irq_enable, .idle_mode, .power_down_mode,
  .osc_run, .cpu_hold);

// >>> bench/power_control_wakeup_tb.sv
// self-checking bench for the power control and wake-up block
`timescale 1ns/1ps
module power_control_wakeup_tb;
  localparam logic [11:0] PC_A  = {power_pkg::POWER_CONTROL_IDX[9:0], 2'h0};
  localparam logic [11:0] CFG_A = {power_pkg::WAKE_CONFIG_IDX[9:0], 2'h0};
  logic                  clk, nrst, ce;
  logic [11:0]           s_axi_awaddr, s_axi_araddr;
  logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                  s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0]           s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]            s_axi_wstrb;
  logic [1:0]            s_axi_bresp, s_axi_rresp, rsp;
  power_pkg::irq_vec_t   irq_request, irq_enable, irq_prio_ok;
  power_pkg::reset_evt_t reset_evt;
  logic                  uart_baud_doubler, serial_bit7_select, idle_mode, power_down_mode, osc_run, cpu_hold;
  int                    fail_count, n_compared;

  power_control_wakeup DUT (.clk, .nrst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_request,
    .irq_enable, .irq_prio_ok, .reset_evt, .uart_baud_doubler, .serial_bit7_select, .idle_mode,
    .power_down_mode, .osc_run, .cpu_hold);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task tally_and_finish;
    if (fail_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one write, each channel released when taken
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 100);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
    if (n >= 100) fail_count++;
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d);
    int n;
    @(posedge clk);
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 100);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    rsp = s_axi_rresp;
    if (n >= 100) fail_count++;
  endtask

  // one-cycle event pulse
  task automatic pulse(input power_pkg::irq_vec_t v, input power_pkg::reset_evt_t r);
    @(posedge clk);
    irq_request <= v;
    reset_evt <= r;
    @(posedge clk);
    irq_request <= '0;
    reset_evt <= '0;
  endtask

  // waits for power-down exit and measures the settling hold
  task automatic expect_wake(input int n_exp);
    int n;
    n = 0;
    while (power_down_mode === 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    check(osc_run, 1'b1);
    n = 0;
    while (cpu_hold === 1'b1 && n < 2000) begin
      n++;
      @(posedge clk);
    end
    check(n, n_exp);
  endtask

  task automatic stays_down;
    repeat (3) @(posedge clk);
    check(power_down_mode, 1'b1);
  endtask

  task automatic t_fields;
    axi_read(PC_A, rd);
    check(rd, 32'h30);
    axi_write(PC_A, 32'hFC);
    check(rsp, power_pkg::RESP_OKAY);
    axi_read(PC_A, rd);
    check(rd, 32'hFC);
    check(uart_baud_doubler, 1'b1);
    check(serial_bit7_select, 1'b1);
    axi_write(PC_A, 32'h00);
    axi_read(PC_A, rd);
    check(rd, 32'h00);
    axi_read(12'h300, rd);
    check(rd, 32'h0);
    check(rsp, power_pkg::RESP_SLVERR);
    axi_write({power_pkg::POWER_STATUS_IDX[9:0], 2'h0}, 32'h0);
    check(rsp, power_pkg::RESP_SLVERR);
  endtask

  task automatic t_idle;
    axi_write(PC_A, 32'h01);
    repeat (2) @(posedge clk);
    check({idle_mode, cpu_hold}, 2'h3);
    irq_enable <= 8'h40;
    pulse(8'h40, '0);
    repeat (3) @(posedge clk);
    check(idle_mode, 1'b0);
    axi_read(PC_A, rd);
    check(rd, 32'h00);
  endtask

  task automatic t_pdown;
    irq_enable <= '0;
    axi_write(PC_A, 32'h03);
    repeat (2) @(posedge clk);
    check({power_down_mode, idle_mode, osc_run}, 3'h4);
    pulse(8'h80, '0);
    stays_down();
    irq_enable <= 8'h80;
    pulse(8'h80, '0);
    stays_down();
    irq_prio_ok <= 8'h80;
    pulse(8'h80, '0);
    expect_wake(256);
    axi_read(PC_A, rd);
    check(rd, 32'h00);
  endtask

  task automatic t_resets;
    irq_enable <= '0;
    axi_write(PC_A, 32'h02);
    pulse('0, 3'h1);
    stays_down();
    pulse('0, 3'h2);
    stays_down();
    pulse('0, 3'h4);
    expect_wake(256);
    axi_read(PC_A, rd);
    check(rd, 32'h20);
    axi_write(CFG_A, 32'h280);
    axi_write(PC_A, 32'h22);
    pulse('0, 3'h2);
    expect_wake(1024);
    axi_read(PC_A, rd);
    check(rd, 32'h20);
  endtask

  // interrupt wake sources, first unqualified, then set up
  task automatic t_sources;
    irq_enable <= 8'hFF;
    irq_prio_ok <= 8'hFF;
    axi_write(PC_A, 32'h02);
    pulse(8'h04, '0);
    stays_down();
    pulse(8'h20, '0);
    stays_down();
    pulse(8'h18, '0);
    stays_down();
    pulse(8'h01, '0);
    stays_down();
    pulse(8'h02, '0);
    stays_down();
    axi_write(CFG_A, 32'h3B);
    pulse(8'h20, '0);
    expect_wake(256);
    axi_write(PC_A, 32'h02);
    pulse(8'h10, '0);
    expect_wake(256);
    axi_write(PC_A, 32'h02);
    pulse(8'h01, '0);
    expect_wake(256);
    axi_write(PC_A, 32'h02);
    pulse(8'h02, '0);
    expect_wake(256);
  endtask

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // main sequence
  initial begin
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    ce = 1'b1;
    s_axi_wstrb = 4'hF;
    {irq_request, irq_enable, irq_prio_ok, reset_evt} = '0;
    fail_count = 0;
    n_compared = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_fields();
    t_idle();
    t_pdown();
    t_resets();
    t_sources();
    tally_and_finish();
  end

  // watchdog against a hang
  initial begin
    #80000;
    fail_count++;
    tally_and_finish();
  end
endmodule // power_control_wakeup_tb

// >>> verilog/power_control_wakeup.sv
// power control register, low-power modes and wake-up sequencing behind an axi4-lite slave
`timescale 1ns/1ps
module power_control_wakeup #(
  parameter int ADDR_W = 12
) (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    ce,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0]       s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [ADDR_W-1:0]       s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // events from the rest of the chip
  input  wire power_pkg::irq_vec_t     irq_request,
  input  wire power_pkg::irq_vec_t     irq_enable,
  input  wire power_pkg::irq_vec_t     irq_prio_ok,
  input  wire power_pkg::reset_evt_t   reset_evt,
  // controls to the rest of the chip
  output logic                         uart_baud_doubler,
  output logic                         serial_bit7_select,
  output logic                         idle_mode,
  output logic                         power_down_mode,
  output logic                         osc_run,
  output logic                         cpu_hold
);

  // the index map needs address bits up to byte address 0x227
  if (ADDR_W < 10 || ADDR_W > 32) begin : g_addr_check
    $error("ADDR_W must lie between 10 and 32");
  end

  localparam int HOLD_W_L = power_pkg::HOLD_W;
  localparam logic [HOLD_W_L-1:0] HOLD_XTAL = HOLD_W_L'(power_pkg::OSC_XTAL_CLKS);
  localparam logic [HOLD_W_L-1:0] HOLD_RC   = HOLD_W_L'(power_pkg::OSC_RC_CLKS);

  logic [7:0]                pctl_reg;
  power_pkg::wake_config_t   cfg_reg;
  power_pkg::power_state_t   state_reg;
  logic [HOLD_W_L-1:0]       hold_cnt_reg;
  logic [ADDR_W-1:0]         awaddr_reg;
  logic [31:0]               wdata_reg;
  logic [3:0]                wstrb_reg;
  logic                      irq_wake;
  logic                      reset_wake;
  logic                      do_write;
  logic                      wr_pctl;
  logic                      wr_config;
  logic                      any_reset;
  logic                      reset_apply;
  logic                      idle_exit;
  logic                      pd_exit;
  logic                      enter_pd;
  logic                      enter_idle;
  power_pkg::reg_sel_t       wsel;
  power_pkg::reg_sel_t       rsel;

  // maps a byte address onto one of the registers
  function automatic power_pkg::reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] idx;
    idx = addr >> 2;
    if (addr[1:0] != 2'h0) begin
      decode = power_pkg::SEL_NONE;
    end else if (idx == ADDR_W'(power_pkg::POWER_CONTROL_IDX)) begin
      decode = power_pkg::SEL_PCTL;
    end else if (idx == ADDR_W'(power_pkg::WAKE_CONFIG_IDX)) begin
      decode = power_pkg::SEL_CONFIG;
    end else if (idx == ADDR_W'(power_pkg::POWER_STATUS_IDX)) begin
      decode = power_pkg::SEL_STATUS;
    end else begin
      decode = power_pkg::SEL_NONE;
    end
  endfunction

  wake_qualify u_wake_qualify (
    .irq_request (irq_request),
    .irq_enable  (irq_enable),
    .irq_prio_ok (irq_prio_ok),
    .reset_evt   (reset_evt),
    .cfg         (cfg_reg),
    .irq_wake    (irq_wake),
    .reset_wake  (reset_wake)
  );

  // write strobes once address and data are both held
  assign do_write  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wsel      = decode(awaddr_reg);
  assign rsel      = decode(s_axi_araddr);
  assign wr_pctl   = do_write && wsel == power_pkg::SEL_PCTL && wstrb_reg[0];
  assign wr_config = do_write && wsel == power_pkg::SEL_CONFIG;

  // a reset counts while running; in power down only a qualified one acts
  assign any_reset   = |reset_evt;
  assign reset_apply = (state_reg == power_pkg::ST_PDOWN) ? reset_wake : any_reset;
  assign idle_exit   = state_reg == power_pkg::ST_IDLE
                    && (|(irq_request & irq_enable) || any_reset);
  assign pd_exit     = state_reg == power_pkg::ST_PDOWN && (irq_wake || reset_wake);
  assign enter_pd    = state_reg == power_pkg::ST_RUN && wr_pctl
                    && wdata_reg[power_pkg::BIT_POWER_DOWN];
  assign enter_idle  = state_reg == power_pkg::ST_RUN && wr_pctl && !enter_pd
                    && wdata_reg[power_pkg::BIT_IDLE];

  // power control register: reset cause, software writes, hardware sets and clears
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pctl_reg <= power_pkg::PCTL_RESET_POR;
    end else if (ce) begin
      if (reset_apply && reset_evt.brownout) begin
        pctl_reg <= power_pkg::PCTL_RESET_BOR
                  | (pctl_reg & power_pkg::PCTL_KEEP_BOR);
      end else if (reset_apply) begin
        pctl_reg <= power_pkg::PCTL_RESET_OTHER
                  | (pctl_reg & power_pkg::PCTL_KEEP_OTHER);
      end else begin
        if (wr_pctl) begin
          pctl_reg[power_pkg::BIT_BAUD_DOUBLER] <= wdata_reg[power_pkg::BIT_BAUD_DOUBLER];
          pctl_reg[power_pkg::BIT_BIT7_SELECT]  <= wdata_reg[power_pkg::BIT_BIT7_SELECT];
          pctl_reg[power_pkg::BIT_USER_ONE]     <= wdata_reg[power_pkg::BIT_USER_ONE];
          pctl_reg[power_pkg::BIT_USER_ZERO]    <= wdata_reg[power_pkg::BIT_USER_ZERO];
          // cause flags: a written 0 clears, a written 1 changes nothing
          pctl_reg[power_pkg::BIT_POWER_ON] <= pctl_reg[power_pkg::BIT_POWER_ON]
                                             & wdata_reg[power_pkg::BIT_POWER_ON];
          pctl_reg[power_pkg::BIT_BROWNOUT] <= (pctl_reg[power_pkg::BIT_BROWNOUT]
                                             & wdata_reg[power_pkg::BIT_BROWNOUT])
                                             | irq_request.brownout;
        end else if (irq_request.brownout) begin
          pctl_reg[power_pkg::BIT_BROWNOUT] <= 1'b1;
        end
        // mode requests set by software, cleared by hardware on exit
        if (enter_pd) begin
          pctl_reg[power_pkg::BIT_POWER_DOWN] <= 1'b1;
        end else if (pd_exit) begin
          pctl_reg[power_pkg::BIT_POWER_DOWN] <= 1'b0;
        end
        if (enter_idle) begin
          pctl_reg[power_pkg::BIT_IDLE] <= 1'b1;
        end else if (idle_exit) begin
          pctl_reg[power_pkg::BIT_IDLE] <= 1'b0;
        end
      end
    end
  end

  // wake-up qualifier register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_reg <= power_pkg::WAKE_CONFIG_RESET;
    end else if (ce && wr_config) begin
      if (wstrb_reg[0]) begin
        cfg_reg[7:0] <= wdata_reg[7:0];
      end
      if (wstrb_reg[1]) begin
        cfg_reg[15:8] <= {6'h00, wdata_reg[9:8]};
      end
    end
  end

  // mode sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg    <= power_pkg::ST_RUN;
      hold_cnt_reg <= '0;
    end else if (ce) begin
      unique case (state_reg)
        power_pkg::ST_RUN: begin
          if (enter_pd) begin
            state_reg <= power_pkg::ST_PDOWN;
          end else if (enter_idle) begin
            state_reg <= power_pkg::ST_IDLE;
          end
        end
        power_pkg::ST_IDLE: begin
          if (idle_exit) begin
            state_reg <= power_pkg::ST_RUN;
          end
        end
        power_pkg::ST_PDOWN: begin
          if (pd_exit) begin
            state_reg    <= power_pkg::ST_WAKE;
            hold_cnt_reg <= cfg_reg.osc_crystal ? HOLD_XTAL : HOLD_RC;
          end
        end
        power_pkg::ST_WAKE: begin
          if (hold_cnt_reg == HOLD_W_L'(1)) begin
            state_reg <= power_pkg::ST_RUN;
          end
          hold_cnt_reg <= hold_cnt_reg - HOLD_W_L'(1);
        end
      endcase
    end
  end

  // mode outputs, registered from the next state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idle_mode       <= 1'b0;
      power_down_mode <= 1'b0;
      osc_run         <= 1'b1;
      cpu_hold        <= 1'b0;
    end else if (ce) begin
      idle_mode       <= (state_reg == power_pkg::ST_IDLE && !idle_exit) || enter_idle;
      power_down_mode <= (state_reg == power_pkg::ST_PDOWN && !pd_exit) || enter_pd;
      osc_run         <= !((state_reg == power_pkg::ST_PDOWN && !pd_exit) || enter_pd);
      cpu_hold        <= enter_pd || enter_idle
                      || (state_reg == power_pkg::ST_IDLE && !idle_exit)
                      || state_reg == power_pkg::ST_PDOWN
                      || (state_reg == power_pkg::ST_WAKE && hold_cnt_reg != HOLD_W_L'(1));
    end
  end

  // uart controls come straight off the register
  assign uart_baud_doubler  = pctl_reg[power_pkg::BIT_BAUD_DOUBLER];
  assign serial_bit7_select = pctl_reg[power_pkg::BIT_BIT7_SELECT];

  // write address and data channels, taken in either order
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b1;
      awaddr_reg    <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_reg    <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_wready <= 1'b1;
      wdata_reg    <= '0;
      wstrb_reg    <= '0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // write response; status register is read-only and answers with an error
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= power_pkg::RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wsel == power_pkg::SEL_PCTL || wsel == power_pkg::SEL_CONFIG)
                      ? power_pkg::RESP_OKAY : power_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel: data one edge after the address is taken
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= power_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= power_pkg::RESP_OKAY;
        unique case (rsel)
          power_pkg::SEL_PCTL:   s_axi_rdata <= {24'h000000, pctl_reg};
          power_pkg::SEL_CONFIG: s_axi_rdata <= {16'h0000, cfg_reg};
          power_pkg::SEL_STATUS: s_axi_rdata <= {26'h0000000, irq_wake, reset_wake,
                                                 osc_run, cpu_hold, state_reg};
          power_pkg::SEL_NONE: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= power_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // power_control_wakeup

// >>> verilog/power_pkg.sv
// constants, register map and carrier types for the power control and wake-up block
package power_pkg;

  // register indices; byte address is four times the index
  localparam logic [11:0] POWER_CONTROL_IDX = 12'h087;
  localparam logic [11:0] WAKE_CONFIG_IDX   = 12'h088;
  localparam logic [11:0] POWER_STATUS_IDX  = 12'h089;

  // power_control_reg field positions
  localparam int BIT_BAUD_DOUBLER = 7;
  localparam int BIT_BIT7_SELECT  = 6;
  localparam int BIT_BROWNOUT     = 5;
  localparam int BIT_POWER_ON     = 4;
  localparam int BIT_USER_ONE     = 3;
  localparam int BIT_USER_ZERO    = 2;
  localparam int BIT_POWER_DOWN   = 1;
  localparam int BIT_IDLE         = 0;

  // power_control_reg load values per reset cause
  localparam logic [7:0] PCTL_RESET_POR   = 8'h30;
  localparam logic [7:0] PCTL_RESET_BOR   = 8'h20;
  localparam logic [7:0] PCTL_RESET_OTHER = 8'h00;
  // cause flags that survive a brownout or other reset
  localparam logic [7:0] PCTL_KEEP_BOR    = 8'h10;
  localparam logic [7:0] PCTL_KEEP_OTHER  = 8'h30;

  localparam logic [15:0] WAKE_CONFIG_RESET = 16'h0000;

  // oscillator stabilisation holds, in cpu clocks
  localparam int OSC_XTAL_CLKS = 1024;
  localparam int OSC_RC_CLKS   = 256;
  localparam int HOLD_W        = 11;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // software-held qualifiers for each wake source except ext0 and ext1, which need none
  typedef struct packed {
    logic [5:0] spare;
    logic       osc_crystal;
    logic       ext_reset_enable;
    logic       watchdog_enable_fuse;
    logic       brownout_disable;
    logic       brownout_irq_select;
    logic       adc_rc_clock_select;
    logic       adc_setup;
    logic       cmp2_setup;
    logic       cmp1_setup;
    logic       kbi_setup;
  } wake_config_t;

  // one bit per interrupt source
  typedef struct packed {
    logic ext0;
    logic ext1;
    logic kbi;
    logic cmp1;
    logic cmp2;
    logic wdt;
    logic brownout;
    logic adc;
  } irq_vec_t;

  // reset events arriving from the reset generator
  typedef struct packed {
    logic brownout;
    logic watchdog;
    logic pin;
  } reset_evt_t;

  typedef enum logic [1:0] {ST_RUN, ST_IDLE, ST_PDOWN, ST_WAKE} power_state_t;

  typedef enum logic [1:0] {SEL_PCTL, SEL_CONFIG, SEL_STATUS, SEL_NONE} reg_sel_t;

endpackage

// >>> verilog/wake_qualify.sv
// qualifies interrupt and reset events as power-down wake-up sources
`timescale 1ns/1ps
module wake_qualify (
  input  power_pkg::irq_vec_t     irq_request,
  input  power_pkg::irq_vec_t     irq_enable,
  input  power_pkg::irq_vec_t     irq_prio_ok,
  input  power_pkg::reset_evt_t   reset_evt,
  input  power_pkg::wake_config_t cfg,
  output logic                    irq_wake,
  output logic                    reset_wake
);

  power_pkg::irq_vec_t ready;

  // per-source setup and enable conditions
  always_comb begin
    ready.ext0     = 1'b1;
    ready.ext1     = 1'b1;
    ready.kbi      = cfg.kbi_setup;
    ready.cmp1     = cfg.cmp1_setup;
    ready.cmp2     = cfg.cmp2_setup;
    ready.wdt      = !cfg.watchdog_enable_fuse;
    ready.brownout = !cfg.brownout_disable && cfg.brownout_irq_select;
    ready.adc      = cfg.adc_rc_clock_select && cfg.adc_setup;
  end

  // an interrupt wakes only if enabled, set up and above the active priority
  assign irq_wake = |(irq_request & irq_enable & irq_prio_ok & ready);

  // reset sources that may end power down
  assign reset_wake = (reset_evt.watchdog && cfg.watchdog_enable_fuse)
                   || (reset_evt.brownout && !cfg.brownout_disable
                       && !cfg.brownout_irq_select)
                   || (reset_evt.pin && cfg.ext_reset_enable);

endmodule // wake_qualify
